// ### hw/dpms_consts.vh
// Constants for the run/stop supervisor of the fieldbus master
`ifndef DPMS_CONSTS_VH
`define DPMS_CONSTS_VH
`define DPMS_NSLV 8
`define DPMS_IOW 8
`define DPMS_CLK_HZ 50000000
`define DPMS_WD_MS 500
`define DPMS_TICK_HZ 1000
`define DPMS_PRE_W 16
`define DPMS_WD_W 10
// Default watchdog: 1 ms ticks at 50 MHz, 500 of them give 0.5 s
`define DPMS_WD_PRESCALE 16'hC350
`define DPMS_WD_TERMINAL 10'h1F4
`define DPMS_ST_STOP 2'h0
`define DPMS_ST_RUN 2'h1
`define DPMS_SL_OK 2'h0
`define DPMS_SL_FAIL 2'h1
`define DPMS_SL_REPRM 2'h2
`endif

// ### hw/dpms_watchdog.v
// Control-processor watchdog of the communication processor
`timescale 1ns/1ps
`include "dpms_consts.vh"
module dpms_watchdog #(
  parameter [`DPMS_PRE_W-1:0] PRESCALE = `DPMS_WD_PRESCALE,
  parameter [`DPMS_WD_W-1:0] TERMINAL = `DPMS_WD_TERMINAL
) (
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Control
  input wire start,
  input wire stop,
  input wire kick,
  // Status
  output reg expired
);
  reg [`DPMS_PRE_W-1:0] pre_reg;
  reg [`DPMS_WD_W-1:0] cnt_reg;
  reg run_reg;
  wire tick = (pre_reg == PRESCALE - 1'b1);
  always @(posedge mclk) begin
    if (srst) begin
      pre_reg <= {`DPMS_PRE_W{1'b0}};
      cnt_reg <= {`DPMS_WD_W{1'b0}};
      run_reg <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        run_reg <= 1'b0;
        pre_reg <= {`DPMS_PRE_W{1'b0}};
        cnt_reg <= {`DPMS_WD_W{1'b0}};
      end else if (start || (run_reg && kick)) begin
        run_reg <= 1'b1;
        pre_reg <= {`DPMS_PRE_W{1'b0}};
        cnt_reg <= {`DPMS_WD_W{1'b0}};
      end else if (run_reg) begin
        pre_reg <= tick ? {`DPMS_PRE_W{1'b0}} : pre_reg + 1'b1;
        if (tick) begin
          if (cnt_reg == TERMINAL - 1'b1) begin
            expired <= 1'b1;
            run_reg <= 1'b0;
            cnt_reg <= {`DPMS_WD_W{1'b0}};
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      end
    end
  end
endmodule // dpms_watchdog

// ### hw/dpms_supervisor.v
// Run/stop, slave failure and watchdog supervisor of the fieldbus master
`timescale 1ns/1ps
`include "dpms_consts.vh"
module dpms_supervisor #(
  parameter [`DPMS_PRE_W-1:0] WD_PRESCALE = `DPMS_WD_PRESCALE,
  parameter [`DPMS_WD_W-1:0] WD_TERMINAL = `DPMS_WD_TERMINAL
) (
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Mode switch and processor events (switch is a pin)
  input wire run_switch,
  input wire iface_startup,
  input wire cycle_checkpoint,
  input wire watchdog_retrigger_block,
  input wire cycle_time_overrun,
  // Bus status
  input wire bus_active,
  input wire [`DPMS_NSLV-1:0] slave_alive,
  input wire [`DPMS_NSLV-1:0] slave_param_done,
  // Application side images
  input wire [`DPMS_NSLV*`DPMS_IOW-1:0] app_out_image,
  input wire [`DPMS_NSLV*`DPMS_IOW-1:0] bus_in_data,
  output reg [`DPMS_NSLV*`DPMS_IOW-1:0] app_in_image,
  output reg [`DPMS_NSLV*`DPMS_IOW-1:0] out_image_int,
  output reg [`DPMS_NSLV*`DPMS_IOW-1:0] bus_out_data,
  output reg [`DPMS_NSLV-1:0] bus_out_valid,
  output reg [`DPMS_NSLV-1:0] reparam_req,
  // Status
  output reg ctrl_run,
  output reg io_access_en,
  output reg slaves_force_zero,
  output reg [`DPMS_NSLV-1:0] slave_diag_fail,
  output reg overview_diag_fail,
  output reg cp_notify_overrun,
  output reg cp_notify_cpu_fail,
  output reg periphery_not_ready_report,
  output reg acknowledge_timeout_report
);
  reg sw_meta_reg;
  reg sw_sync_reg;
  reg run_prev_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2*`DPMS_NSLV-1:0] sl_st_reg;
  wire wd_expired;

  // Run needs a fresh rising edge of the switch, so a forced stop sticks
  wire go_run = (state_reg == `DPMS_ST_STOP) && sw_sync_reg && !run_prev_reg;
  wire go_stop = (state_reg == `DPMS_ST_RUN) && (!sw_sync_reg || wd_expired);

  // Watchdog controls; an expiry-forced stop needs no separate halt
  wire wd_start = iface_startup || go_run;
  wire wd_stop = go_stop && !wd_expired;
  wire wd_kick = cycle_checkpoint || watchdog_retrigger_block;

  // Mode switch is a pin: two flip-flops before any logic
  always @(posedge mclk) begin
    if (srst) begin
      sw_meta_reg <= 1'b0;
      sw_sync_reg <= 1'b0;
    end else begin
      sw_meta_reg <= run_switch;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `DPMS_ST_STOP: begin
        if (go_run)
          state_next = `DPMS_ST_RUN;
      end
      `DPMS_ST_RUN: begin
        if (go_stop)
          state_next = `DPMS_ST_STOP;
      end
      default: state_next = `DPMS_ST_STOP;
    endcase
  end

  // Switch must return to stop after a forced stop before a new run
  always @(posedge mclk) begin
    if (srst) begin
      state_reg <= `DPMS_ST_STOP;
      run_prev_reg <= 1'b1;
      ctrl_run <= 1'b0;
      io_access_en <= 1'b0;
      slaves_force_zero <= 1'b1;
    end else begin
      state_reg <= state_next;
      run_prev_reg <= sw_sync_reg;
      ctrl_run <= (state_next == `DPMS_ST_RUN);
      io_access_en <= (state_next == `DPMS_ST_RUN);
      slaves_force_zero <= (state_next != `DPMS_ST_RUN);
    end
  end

  // Bus faults show up only in overview and per-slave diagnostics, never as an access trap
  always @(posedge mclk) begin
    if (srst) begin
      overview_diag_fail <= 1'b0;
    end else begin
      overview_diag_fail <= !bus_active || (slave_alive != {`DPMS_NSLV{1'b1}});
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      cp_notify_overrun <= 1'b0;
      cp_notify_cpu_fail <= 1'b0;
      periphery_not_ready_report <= 1'b0;
      acknowledge_timeout_report <= 1'b0;
    end else begin
      cp_notify_overrun <= cycle_time_overrun;
      cp_notify_cpu_fail <= wd_expired;
      periphery_not_ready_report <= 1'b0;
      acknowledge_timeout_report <= 1'b0;
    end
  end

  dpms_watchdog #(
    .PRESCALE(WD_PRESCALE),
    .TERMINAL(WD_TERMINAL)
  ) u_wd (
    .mclk(mclk),
    .srst(srst),
    .start(wd_start),
    .stop(wd_stop),
    .kick(wd_kick),
    .expired(wd_expired)
  );

  // Per-slave failure and recovery handling
  genvar i;
  generate
    for (i = 0; i < `DPMS_NSLV; i = i + 1) begin : g_slv
      wire up = bus_active && slave_alive[i];
      wire [1:0] st = sl_st_reg[2*i+1:2*i];
      wire healthy = up && (st == `DPMS_SL_OK);
      reg [1:0] st_next;
      // A recovered slave always passes through re-parameterization
      always @* begin
        st_next = st;
        case (st)
          `DPMS_SL_OK: begin
            if (!up)
              st_next = `DPMS_SL_FAIL;
          end
          `DPMS_SL_FAIL: begin
            if (up)
              st_next = `DPMS_SL_REPRM;
          end
          `DPMS_SL_REPRM: begin
            if (!up)
              st_next = `DPMS_SL_FAIL;
            else if (slave_param_done[i])
              st_next = `DPMS_SL_OK;
          end
          default: st_next = `DPMS_SL_FAIL;
        endcase
      end
      always @(posedge mclk) begin
        if (srst) begin
          sl_st_reg[2*i+1:2*i] <= `DPMS_SL_REPRM;
          reparam_req[i] <= 1'b0;
          slave_diag_fail[i] <= 1'b0;
        end else begin
          sl_st_reg[2*i+1:2*i] <= st_next;
          reparam_req[i] <= up && (st == `DPMS_SL_REPRM);
          slave_diag_fail[i] <= !up;
        end
      end
      // Stopped master clears inputs too; access is blocked anyway
      always @(posedge mclk) begin
        if (srst) begin
          app_in_image[i*`DPMS_IOW +: `DPMS_IOW] <= {`DPMS_IOW{1'b0}};
        end else if (!up || !ctrl_run) begin
          app_in_image[i*`DPMS_IOW +: `DPMS_IOW] <= {`DPMS_IOW{1'b0}};
        end else if (healthy) begin
          app_in_image[i*`DPMS_IOW +: `DPMS_IOW] <= bus_in_data[i*`DPMS_IOW +: `DPMS_IOW];
        end
      end
      // Internal image keeps tracking the application even for a failed slave
      always @(posedge mclk) begin
        if (srst) begin
          out_image_int[i*`DPMS_IOW +: `DPMS_IOW] <= {`DPMS_IOW{1'b0}};
        end else if (ctrl_run) begin
          out_image_int[i*`DPMS_IOW +: `DPMS_IOW] <= app_out_image[i*`DPMS_IOW +: `DPMS_IOW];
        end
      end
      // Delivery only to healthy, parameterized slaves while running
      always @(posedge mclk) begin
        if (srst) begin
          bus_out_valid[i] <= 1'b0;
          bus_out_data[i*`DPMS_IOW +: `DPMS_IOW] <= {`DPMS_IOW{1'b0}};
        end else begin
          bus_out_valid[i] <= healthy && ctrl_run;
          if (!ctrl_run)
            bus_out_data[i*`DPMS_IOW +: `DPMS_IOW] <= {`DPMS_IOW{1'b0}};
          else if (healthy)
            bus_out_data[i*`DPMS_IOW +: `DPMS_IOW] <= out_image_int[i*`DPMS_IOW +: `DPMS_IOW];
        end
      end
    end
  endgenerate
endmodule // dpms_supervisor

// ### bench/dpms_supervisor_sva.sv
// Assertion checker for the run/stop supervisor
`timescale 1ns/1ps
module dpms_sva (
  // Clock and reset
  input wire mclk,
  input wire srst,
  // Stimulus seen
  input wire cycle_checkpoint,
  input wire cycle_time_overrun,
  input wire [7:0] slave_alive,
  // Outputs watched
  input wire ctrl_run,
  input wire io_access_en,
  input wire slaves_force_zero,
  input wire periphery_not_ready_report,
  input wire acknowledge_timeout_report,
  input wire cp_notify_overrun,
  input wire cp_notify_cpu_fail,
  input wire [63:0] app_in_image,
  input wire [7:0] reparam_req,
  input wire [7:0] bus_out_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  AST_ACCESS: assert property (io_access_en == ctrl_run) else $error("access enable differs from run");
  AST_FORCE0: assert property (slaves_force_zero == !ctrl_run) else $error("force zero wrong");
  AST_NOTRAP: assert property (!(periphery_not_ready_report || acknowledge_timeout_report)) else $error("trap raised");
  AST_FAILIN: assert property (ctrl_run && $fell(slave_alive[2]) |=> ctrl_run && app_in_image[23:16] == 8'h00
    && !bus_out_valid[2]) else $error("failed slave not isolated");
  AST_REPRM: assert property (reparam_req[2] |-> !bus_out_valid[2]) else $error("outputs before reparam");
  AST_OVR: assert property (cycle_time_overrun |=> cp_notify_overrun) else $error("overrun not notified");
  AST_CPUSTOP: assert property (cp_notify_cpu_fail |-> ##[0:3] !ctrl_run) else $error("no stop on expiry");
  AST_WDHALT: assert property ($fell(ctrl_run) |-> ##3 !cp_notify_cpu_fail [*8]) else $error("expiry in stop");
  AST_WDRUN: assert property ($rose(ctrl_run) |-> ##3 !cp_notify_cpu_fail [*8]) else $error("stale expiry");
  AST_WDKICK: assert property (ctrl_run && cycle_checkpoint |-> ##3 !cp_notify_cpu_fail [*8])
    else $error("expiry after kick");
  cover property ($rose(ctrl_run));
  cover property (cp_notify_cpu_fail);
  cover property ($fell(bus_out_valid[2]));
endmodule // dpms_sva
bind dpms_supervisor dpms_sva u_dpms_sva (.mclk(mclk), .srst(srst), .cycle_checkpoint(cycle_checkpoint),
  .cycle_time_overrun(cycle_time_overrun), .slave_alive(slave_alive), .ctrl_run(ctrl_run),
  .io_access_en(io_access_en), .slaves_force_zero(slaves_force_zero),
  .periphery_not_ready_report(periphery_not_ready_report), .acknowledge_timeout_report(acknowledge_timeout_report),
  .cp_notify_overrun(cp_notify_overrun), .cp_notify_cpu_fail(cp_notify_cpu_fail), .app_in_image(app_in_image),
  .reparam_req(reparam_req), .bus_out_valid(bus_out_valid));

// ### bench/dpms_slave_model.sv
// Behavioural model of the slave stations on the bus
`timescale 1ns/1ps
module dpms_slave_model (
  // Clock
  input wire mclk,
  // From the master
  input wire [63:0] bus_out_data,
  input wire [7:0] bus_out_valid,
  input wire slaves_force_zero,
  input wire [7:0] rm_en,
  // Slave side
  output logic [63:0] slv_out,
  output wire [63:0] bus_in_data
);
  logic [3:0] quiet [8] = '{default: 4'h0};
  assign bus_in_data = 64'h8877665544332211;
  always @(posedge mclk)
    for (int i = 0; i < 8; i++) begin
      quiet[i] <= bus_out_valid[i] ? 4'h0 : quiet[i] + {3'h0, quiet[i] != 4'hF};
      if (slaves_force_zero) slv_out[i*8 +: 8] <= 8'h00;
      else if (bus_out_valid[i]) slv_out[i*8 +: 8] <= bus_out_data[i*8 +: 8];
      else if (rm_en[i] && quiet[i] == 4'hA) slv_out[i*8 +: 8] <= 8'h00;
    end
endmodule // dpms_slave_model

// ### bench/dpms_supervisor_tb_top.sv
// Testbench for the run/stop supervisor
`timescale 1ns/1ps
module dpms_supervisor_tb_top;
  logic mclk = 0, srst = 1, run_switch = 0, iface_startup = 0, cycle_checkpoint = 0, watchdog_retrigger_block = 0;
  logic cycle_time_overrun = 0, kick_on = 0, fail_seen = 0, ctrl_run, io_access_en, slaves_force_zero, ovw, ovr, cpf;
  logic pnr, atr;
  logic [7:0] rm_en = 8'h00;
  logic [7:0] slave_alive = 8'hFF, slave_param_done = 8'h00, slave_diag_fail, bus_out_valid, reparam_req;
  logic [63:0] app_out_image = 64'h0, bus_in_data, app_in_image, out_image_int, bus_out_data, slv_out;
  logic [63:0] rows [3][2] = '{'{64'h0123456789ABCDEF, 64'h0123456789ABCDEF},
    '{64'hFFFFFFFFFFFFFFFF, 64'hFFFFFFFFFFFFFFFF}, '{64'h0000000000C30000, 64'h0000000000C30000}};
  int num_errors = 0, num_checks = 0;
  dpms_supervisor #(.WD_PRESCALE(16'h0004), .WD_TERMINAL(10'h005)) u_dpms_supervisor (.mclk(mclk), .srst(srst),
    .run_switch(run_switch), .iface_startup(iface_startup), .cycle_checkpoint(cycle_checkpoint),
    .watchdog_retrigger_block(watchdog_retrigger_block), .cycle_time_overrun(cycle_time_overrun), .bus_active(1'b1),
    .slave_alive(slave_alive), .slave_param_done(slave_param_done), .app_out_image(app_out_image),
    .bus_in_data(bus_in_data), .app_in_image(app_in_image), .out_image_int(out_image_int),
    .bus_out_data(bus_out_data), .bus_out_valid(bus_out_valid), .reparam_req(reparam_req), .ctrl_run(ctrl_run),
    .io_access_en(io_access_en), .slaves_force_zero(slaves_force_zero), .slave_diag_fail(slave_diag_fail),
    .overview_diag_fail(ovw), .cp_notify_overrun(ovr), .cp_notify_cpu_fail(cpf),
    .periphery_not_ready_report(pnr), .acknowledge_timeout_report(atr));
  dpms_slave_model u_dpms_slave_model (.mclk(mclk), .bus_out_data(bus_out_data), .bus_out_valid(bus_out_valid),
    .slaves_force_zero(slaves_force_zero), .rm_en(rm_en), .slv_out(slv_out), .bus_in_data(bus_in_data));
  always #10 mclk = ~mclk;
  always @(posedge mclk) cycle_checkpoint <= #2 kick_on & ~cycle_checkpoint;
  always @(posedge mclk) if (cpf) fail_seen <= 1'b1;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    cyc(6);
    srst = 0;
    chk({ctrl_run, io_access_en, slaves_force_zero, pnr, atr}, 5'b00100, "reset state");
    cycle_time_overrun = 1;
    cyc(1);
    cycle_time_overrun = 0;
    chk(ovr, 1'b1, "overrun notice");
    iface_startup = 1;
    cyc(1);
    iface_startup = 0;
    cyc(25);
    chk(fail_seen, 1'b1, "watchdog from start-up");
    kick_on = 1;
    run_switch = 1;
    cyc(6);
    chk({ctrl_run, io_access_en, slaves_force_zero, reparam_req}, 11'h6FF, "run, reparam pending");
    slave_param_done = 8'hFF;
    cyc(3);
    chk(app_in_image, 64'h8877665544332211, "inputs read");
    foreach (rows[r]) begin
      app_out_image = rows[r][0];
      cyc(3);
      chk(slv_out, rows[r][1], "slave outputs");
    end
    $display("run-up and exchange done");
    slave_param_done = 8'h00;
    slave_alive = 8'hFB;
    app_out_image = 64'h5555555555555555;
    cyc(3);
    chk(app_in_image, 64'h8877665544002211, "failed slave inputs");
    chk(out_image_int, 64'h5555555555555555, "internal outputs");
    chk(slv_out, 64'h5555555555C35555, "others refreshed");
    chk(bus_out_data, 64'h5555555555C35555, "failed slave output held");
    chk({ctrl_run, ovw, slave_diag_fail}, 10'h304, "diagnostics only");
    slave_alive = 8'hFF;
    cyc(2);
    chk({reparam_req[2], bus_out_valid[2]}, 2'b10, "reparam first");
    slave_param_done = 8'h04;
    cyc(3);
    chk(slv_out, 64'h5555555555555555, "outputs resume");
    rm_en = 8'h08;
    slave_alive = 8'hF7;
    cyc(14);
    chk(slv_out, 64'h5555555500555555, "monitored slave zeroed");
    slave_alive = 8'hFF;
    slave_param_done = 8'hFF;
    cyc(4);
    chk(slv_out, 64'h5555555555555555, "monitored slave back");
    $display("slave failure done");
    kick_on = 0;
    fail_seen = 0;
    repeat (5) begin
      watchdog_retrigger_block = 1;
      cyc(1);
      watchdog_retrigger_block = 0;
      cyc(10);
    end
    chk({fail_seen, ctrl_run}, 2'b01, "retrigger holds run");
    cyc(20);
    chk({fail_seen, ctrl_run}, 2'b10, "expiry stops");
    chk(slv_out, 64'h0, "expiry zeroes slave outputs");
    run_switch = 0;
    cyc(4);
    kick_on = 1;
    run_switch = 1;
    cyc(30);
    chk(ctrl_run, 1'b1, "restarted run");
    fail_seen = 0;
    run_switch = 0;
    cyc(30);
    chk({fail_seen, io_access_en}, 2'b00, "switch stop");
    chk(app_in_image, 64'h0, "stop blocks inputs");
    chk(slv_out, 64'h0, "stop zeroes outputs");
    $display("watchdog and stop done");
    close_out();
  end
  initial begin
    #40000;
    num_errors++;
    $display("[FAIL] t=%0t run did not finish", $time);
    close_out();
  end
endmodule // dpms_supervisor_tb_top
